// *** design/omc_cfg.svh ***
// constants of the operating mode controller: offsets, fields, reset values
`ifndef OMC_CFG_SVH
`define OMC_CFG_SVH

// ==========================================
// register offsets
`define OMC_OFS_OPTIONS 4'h0
`define OMC_OFS_STATUS 4'h4

// ==========================================
// system options register fields
`define OMC_OPT_STOP_EN 0
`define OMC_OPT_LOWVOLT_DETECT_ENABLE 1
`define OMC_OPT_LOWVOLT_STOP_ENABLE 2
`define OMC_OPT_PPD_SEL 3
`define OMC_OPT_REF_KEEP 4
`define OMC_OPT_WIDTH 5
`define OMC_OPT_RESET 5'h00

// ==========================================
// status register fields
`define OMC_ST_MODE_LSB 0
`define OMC_ST_DBG_EN 4
`define OMC_ST_PD_WOKE 5
`define OMC_ST_STOP_DBG 6
`define OMC_ST_STOP_REG 7

// ==========================================
// vectors
`define OMC_RESET_VECTOR 16'hfffe
`define OMC_DBG_EN_RESET 1'b0

`endif

// *** design/omc_pkg.sv ***
// types of the operating mode controller
package omc_pkg;

    // ==========================================
    // operating modes
    typedef enum logic [2:0] {
        OMC_RUN,
        OMC_HALT,
        OMC_WAIT,
        OMC_STOP_RET,
        OMC_STOP_PD
    } omc_mode_e;

    // ==========================================
    // serial debug commands
    typedef enum logic [2:0] {
        OMC_CMD_MEM,
        OMC_CMD_MEM_STAT,
        OMC_CMD_DREG,
        OMC_CMD_ENTER_DBG,
        OMC_CMD_CPU_REG,
        OMC_CMD_TRACE,
        OMC_CMD_RESUME
    } omc_cmd_e;

endpackage

// *** design/omc_top.sv ***
// operating mode controller: run, debug halt, wait and two stop modes
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "omc_cfg.svh"

module omc_top #(
    parameter int NUM_WAKE = 8
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // pins
    input wire logic MODE_SELECT_PIN,
    input wire logic RESET_PIN_N,
    input wire logic EXT_WAKE_N,
    // cpu decode events
    input wire logic WAIT_EXEC,
    input wire logic STOP_EXEC,
    input wire logic HALT_TO_DEBUG_EXEC,
    input wire logic IRQ_REQ,
    // debug sources
    input wire logic DBG_CMD_VALID,
    input wire omc_pkg::omc_cmd_e DBG_CMD,
    input wire logic DBG_CMD_WDATA,
    input wire logic SERIAL_DEBUG_BKPT,
    input wire logic TRACE_DEBUG_BKPT,
    // retention stop wake interrupts
    input wire logic [NUM_WAKE-1:0] WAKE_IRQ,
    // debug command answer
    output logic CMD_ACCEPT,
    output logic CMD_REFUSE,
    output logic CMD_STATUS_ERR,
    // cpu control
    output logic CPU_CLK_EN,
    output logic CPU_SUSPEND,
    output logic CLEAR_IRQ_MASK,
    output logic IRQ_STACK,
    output logic TRACE_STEP,
    output logic FETCH_VECTOR,
    output logic [15:0] VECTOR_ADDR,
    output logic TAKE_WAKE_VECTOR,
    output logic [3:0] WAKE_SRC,
    output logic ILLEGAL_OP_RESET,
    output logic SYS_RESET,
    output logic POR_RESTART,
    // clocks and power
    output logic BUS_CLK_EN,
    output logic DEBUG_CLK_EN,
    output logic REF_CLK_EN,
    output logic REG_FULL,
    output logic RETAIN_STATE,
    output logic PIN_HOLD,
    output logic POWER_OFF
);
    import omc_pkg::*;

    // wake index is four bits wide, so more than sixteen sources cannot be named
    generate
        if (NUM_WAKE < 1 || NUM_WAKE > 16)
            $error("NUM_WAKE must be 1 to 16");
    endgenerate

    // ==========================================
    // state
    omc_mode_e mode_r, mode_nxt;
    logic boot_r;
    logic [`OMC_OPT_WIDTH-1:0] opt_r;
    logic dbg_en_r, dbg_en_nxt;
    logic pd_woke_r;
    logic stop_dbg_r, stop_dbg_nxt;
    logic stop_reg_r, stop_reg_nxt;
    logic fetch_r, fetch_nxt;
    logic take_r, take_nxt;
    logic [3:0] src_r;
    logic iclr_r, iclr_nxt;
    logic stack_r, stack_nxt;
    logic step_r, step_nxt;
    logic ill_r, ill_nxt;
    logic srst_r, srst_nxt;
    logic por_r, por_nxt;
    logic acc_r, acc_nxt;
    logic ref_r, ref_nxt;
    logic err_r, err_nxt;
    logic ack_r;
    logic [31:0] dat_r;

    // ==========================================
    // decode
    wire bus_req = WB_CYC_I & WB_STB_I & ~ack_r;
    wire sel_opt = WB_ADR_I == `OMC_OFS_OPTIONS;
    wire sel_st = WB_ADR_I == `OMC_OFS_STATUS;
    wire opt_wr = bus_req & WB_WE_I & sel_opt & WB_SEL_I[0];
    wire stop_en = opt_r[`OMC_OPT_STOP_EN];
    wire lv_both = opt_r[`OMC_OPT_LOWVOLT_DETECT_ENABLE] & opt_r[`OMC_OPT_LOWVOLT_STOP_ENABLE];
    wire ppd_sel = opt_r[`OMC_OPT_PPD_SEL];
    wire is_stop = mode_r == OMC_STOP_RET || mode_r == OMC_STOP_PD;
    wire cmd_enter = DBG_CMD_VALID && DBG_CMD == OMC_CMD_ENTER_DBG;
    wire cmd_stat = DBG_CMD_VALID && DBG_CMD == OMC_CMD_MEM_STAT;
    wire cmd_nonint = DBG_CMD == OMC_CMD_MEM || DBG_CMD == OMC_CMD_MEM_STAT ||
                      DBG_CMD == OMC_CMD_DREG || DBG_CMD == OMC_CMD_ENTER_DBG;
    wire bkpt = SERIAL_DEBUG_BKPT | TRACE_DEBUG_BKPT;
    wire any_wake = |WAKE_IRQ;
    wire [7:0] status_v = {stop_reg_r, stop_dbg_r, pd_woke_r, dbg_en_r, 1'b0, mode_r};
    wire [31:0] rd_v = sel_opt ? {27'h0, opt_r} : (sel_st ? {24'h0, status_v} : 32'h0);

    // lowest index wins, so the faster wake sources sit at the bottom
    logic [3:0] pick [NUM_WAKE:0];
    assign pick[NUM_WAKE] = 4'h0;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WAKE; gi++)
        begin : g_pick
            assign pick[gi] = WAKE_IRQ[gi] ? 4'(gi) : pick[gi+1];
        end
    endgenerate

    // ==========================================
    // mode sequencing
    always_comb
    begin
        mode_nxt = mode_r;
        dbg_en_nxt = dbg_en_r;
        stop_dbg_nxt = stop_dbg_r;
        stop_reg_nxt = stop_reg_r;
        fetch_nxt = 1'b0;
        take_nxt = 1'b0;
        iclr_nxt = 1'b0;
        stack_nxt = 1'b0;
        step_nxt = 1'b0;
        ill_nxt = 1'b0;
        srst_nxt = 1'b0;
        por_nxt = 1'b0;
        acc_nxt = 1'b0;
        ref_nxt = 1'b0;
        err_nxt = 1'b0;
        if (boot_r)
        begin
            if (MODE_SELECT_PIN)
            begin
                mode_nxt = OMC_RUN;
                fetch_nxt = 1'b1;
            end
            else
                mode_nxt = OMC_HALT;
        end
        else
        begin
            case (mode_r)
                OMC_RUN:
                begin
                    if (DBG_CMD_VALID)
                    begin
                        acc_nxt = cmd_nonint;
                        ref_nxt = !cmd_nonint;
                    end
                    if (cmd_enter || HALT_TO_DEBUG_EXEC || bkpt)
                        mode_nxt = OMC_HALT;
                    else if (WAIT_EXEC)
                    begin
                        mode_nxt = OMC_WAIT;
                        iclr_nxt = 1'b1;
                    end
                    else if (STOP_EXEC)
                    begin
                        // selection taken now and held until the next stop instruction
                        stop_dbg_nxt = 1'b0;
                        stop_reg_nxt = 1'b0;
                        if (!stop_en)
                            ill_nxt = 1'b1;
                        else if (dbg_en_r)
                        begin
                            mode_nxt = OMC_STOP_RET;
                            stop_dbg_nxt = 1'b1;
                        end
                        else if (lv_both)
                        begin
                            mode_nxt = OMC_STOP_RET;
                            stop_reg_nxt = 1'b1;
                        end
                        else if (ppd_sel)
                            mode_nxt = OMC_STOP_PD;
                        else
                            mode_nxt = OMC_STOP_RET;
                    end
                end
                OMC_HALT:
                begin
                    if (DBG_CMD_VALID)
                    begin
                        acc_nxt = 1'b1;
                        if (DBG_CMD == OMC_CMD_RESUME)
                            mode_nxt = OMC_RUN;
                        step_nxt = DBG_CMD == OMC_CMD_TRACE;
                    end
                end
                OMC_WAIT:
                begin
                    if (DBG_CMD_VALID)
                    begin
                        acc_nxt = cmd_enter | cmd_stat;
                        ref_nxt = !(cmd_enter | cmd_stat);
                        err_nxt = cmd_stat;
                    end
                    if (cmd_enter)
                        mode_nxt = OMC_HALT;
                    else if (IRQ_REQ)
                    begin
                        mode_nxt = OMC_RUN;
                        stack_nxt = 1'b1;
                    end
                end
                OMC_STOP_RET:
                begin
                    // only enter-debug and memory-status commands are accepted, and only while the debug clock runs; all others are refused
                    if (DBG_CMD_VALID)
                    begin
                        acc_nxt = stop_dbg_r & (cmd_enter | cmd_stat);
                        ref_nxt = !(stop_dbg_r & (cmd_enter | cmd_stat));
                        err_nxt = stop_dbg_r & cmd_stat;
                    end
                    if (!RESET_PIN_N)
                    begin
                        mode_nxt = OMC_RUN;
                        srst_nxt = 1'b1;
                        fetch_nxt = 1'b1;
                    end
                    else if (stop_dbg_r && cmd_enter)
                        mode_nxt = OMC_HALT;
                    else if (any_wake)
                    begin
                        mode_nxt = OMC_RUN;
                        take_nxt = 1'b1;
                    end
                end
                OMC_STOP_PD:
                begin
                    ref_nxt = DBG_CMD_VALID;
                    if (!RESET_PIN_N || !EXT_WAKE_N)
                    begin
                        mode_nxt = OMC_RUN;
                        por_nxt = 1'b1;
                        fetch_nxt = 1'b1;
                        dbg_en_nxt = `OMC_DBG_EN_RESET;
                    end
                end
                default:
                    mode_nxt = OMC_RUN;
            endcase
            // debug enable lives behind the debug port only
            if (acc_nxt && DBG_CMD == OMC_CMD_DREG)
                dbg_en_nxt = DBG_CMD_WDATA;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            mode_r <= OMC_RUN;
            boot_r <= 1'b1;
            dbg_en_r <= `OMC_DBG_EN_RESET;
            stop_dbg_r <= 1'b0;
            stop_reg_r <= 1'b0;
            fetch_r <= 1'b0;
            take_r <= 1'b0;
            src_r <= 4'h0;
            iclr_r <= 1'b0;
            stack_r <= 1'b0;
            step_r <= 1'b0;
            ill_r <= 1'b0;
            srst_r <= 1'b0;
            por_r <= 1'b0;
            acc_r <= 1'b0;
            ref_r <= 1'b0;
            err_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            boot_r <= 1'b0;
            dbg_en_r <= dbg_en_nxt;
            stop_dbg_r <= stop_dbg_nxt;
            stop_reg_r <= stop_reg_nxt;
            fetch_r <= fetch_nxt;
            take_r <= take_nxt;
            src_r <= take_nxt ? pick[0] : src_r;
            iclr_r <= iclr_nxt;
            stack_r <= stack_nxt;
            step_r <= step_nxt;
            ill_r <= ill_nxt;
            srst_r <= srst_nxt;
            por_r <= por_nxt;
            acc_r <= acc_nxt;
            ref_r <= ref_nxt;
            err_r <= err_nxt;
        end
    end

    // options clear on a power-down wake, like a power-on reset
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            opt_r <= `OMC_OPT_RESET;
        else if (por_nxt)
            opt_r <= `OMC_OPT_RESET;
        else if (opt_wr)
            opt_r <= WB_DAT_I[`OMC_OPT_WIDTH-1:0];
    end

    // flag survives until a fresh reset of the chip
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            pd_woke_r <= 1'b0;
        else if (por_nxt)
            pd_woke_r <= 1'b1;
    end

    // ==========================================
    // wishbone answer, one wait state
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= bus_req;
            dat_r <= bus_req ? rd_v : 32'h0;
        end
    end

    // ==========================================
    // outputs
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign CMD_ACCEPT = acc_r;
    assign CMD_REFUSE = ref_r;
    assign CMD_STATUS_ERR = err_r;
    assign CPU_CLK_EN = mode_r == OMC_RUN;
    assign CPU_SUSPEND = mode_r == OMC_HALT;
    assign CLEAR_IRQ_MASK = iclr_r;
    assign IRQ_STACK = stack_r;
    assign TRACE_STEP = step_r;
    assign FETCH_VECTOR = fetch_r;
    assign VECTOR_ADDR = `OMC_RESET_VECTOR;
    assign TAKE_WAKE_VECTOR = take_r;
    assign WAKE_SRC = src_r;
    assign ILLEGAL_OP_RESET = ill_r;
    assign SYS_RESET = srst_r;
    assign POR_RESTART = por_r;
    assign BUS_CLK_EN = !is_stop;
    assign DEBUG_CLK_EN = !is_stop || stop_dbg_r;
    // reference clocks may run on through retention stop when software asks
    assign REF_CLK_EN = !is_stop || (mode_r == OMC_STOP_RET && opt_r[`OMC_OPT_REF_KEEP]);
    assign REG_FULL = !is_stop || stop_dbg_r || stop_reg_r;
    assign RETAIN_STATE = mode_r == OMC_STOP_RET;
    assign PIN_HOLD = is_stop;
    assign POWER_OFF = mode_r == OMC_STOP_PD;

endmodule // omc_top

// *** verif/omc_assertions.sv ***
// port checker for the operating mode controller
`timescale 1ns/1ps
// ========
// checker
module omc_assertions (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // debug command
    input wire logic DBG_CMD_VALID,
    input wire omc_pkg::omc_cmd_e DBG_CMD,
    input wire logic CMD_ACCEPT,
    input wire logic CMD_REFUSE,
    input wire logic CMD_STATUS_ERR,
    // cpu and power
    input wire logic CPU_CLK_EN,
    input wire logic CPU_SUSPEND,
    input wire logic CLEAR_IRQ_MASK,
    input wire logic POR_RESTART,
    input wire logic RESET_PIN_N,
    input wire logic EXT_WAKE_N,
    input wire logic BUS_CLK_EN,
    input wire logic REF_CLK_EN,
    input wire logic REG_FULL,
    input wire logic POWER_OFF
);
    import omc_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    // restart pulse may lag the mode register by up to two cycles
    sequence s_restart;
        ##[0:2] POR_RESTART;
    endsequence
    chk_cmd_answer: assert property (DBG_CMD_VALID |=> CMD_ACCEPT != CMD_REFUSE)
        else $error("debug command without single answer");
    chk_run_refuse: assert property (DBG_CMD_VALID && CPU_CLK_EN && DBG_CMD > OMC_CMD_ENTER_DBG
        |=> CMD_REFUSE) else $error("halt-only command taken in run");
    chk_err_accept: assert property (CMD_STATUS_ERR
        |-> CMD_ACCEPT && !$past(CPU_CLK_EN) && !$past(CPU_SUSPEND)) else $error("status error outside wait or stop");
    chk_halt_cpu: assert property (CPU_SUSPEND |-> !CPU_CLK_EN)
        else $error("cpu clocked while suspended");
    chk_wait_clocks: assert property (CLEAR_IRQ_MASK |-> BUS_CLK_EN && REG_FULL && !CPU_CLK_EN)
        else $error("wait entry with wrong clocks");
    chk_stop_clocks: assert property (!BUS_CLK_EN |-> !CPU_CLK_EN)
        else $error("cpu clocked with bus clock off");
    chk_pd_power: assert property (POWER_OFF |-> !BUS_CLK_EN && !REF_CLK_EN)
        else $error("clocks running in power-down");
    chk_pd_exit: assert property ($fell(POWER_OFF) |-> !$past(RESET_PIN_N) || !$past(EXT_WAKE_N)
        || !$past(RESET_PIN_N, 2) || !$past(EXT_WAKE_N, 2)) else $error("power-down left without wake pin");
    chk_pd_restart: assert property ($fell(POWER_OFF) |-> s_restart)
        else $error("power-down exit without restart");
endmodule // omc_assertions

bind omc_top omc_assertions chk (.MCLK(MCLK), .RST(RST), .DBG_CMD_VALID(DBG_CMD_VALID), .DBG_CMD(DBG_CMD),
    .CMD_ACCEPT(CMD_ACCEPT), .CMD_REFUSE(CMD_REFUSE), .CMD_STATUS_ERR(CMD_STATUS_ERR), .CPU_CLK_EN(CPU_CLK_EN),
    .CPU_SUSPEND(CPU_SUSPEND), .CLEAR_IRQ_MASK(CLEAR_IRQ_MASK), .POR_RESTART(POR_RESTART),
    .RESET_PIN_N(RESET_PIN_N), .EXT_WAKE_N(EXT_WAKE_N), .BUS_CLK_EN(BUS_CLK_EN), .REF_CLK_EN(REF_CLK_EN),
    .REG_FULL(REG_FULL), .POWER_OFF(POWER_OFF));

// *** verif/omc_partner.sv ***
// far-side model: cpu decode, serial debug host and wake sources
`timescale 1ns/1ps
// ========
// partner
module omc_partner #(
    parameter int NUM_WAKE = 8
) (
    // clock
    input wire logic MCLK,
    // cpu decode and breakpoints
    output logic WAIT_EXEC,
    output logic STOP_EXEC,
    output logic HALT_TO_DEBUG_EXEC,
    output logic SERIAL_DEBUG_BKPT,
    output logic TRACE_DEBUG_BKPT,
    output logic IRQ_REQ,
    // debug host
    output logic DBG_CMD_VALID,
    output omc_pkg::omc_cmd_e DBG_CMD,
    output logic DBG_CMD_WDATA,
    // wake sources
    output logic [NUM_WAKE-1:0] WAKE_IRQ,
    output logic RESET_PIN_N,
    output logic EXT_WAKE_N
);
    import omc_pkg::*;
    logic [4:0] ev_r = 5'h00;
    assign {TRACE_DEBUG_BKPT, SERIAL_DEBUG_BKPT, HALT_TO_DEBUG_EXEC, STOP_EXEC, WAIT_EXEC} = ev_r;
    initial
    begin
        IRQ_REQ = 1'b0;
        DBG_CMD_VALID = 1'b0;
        DBG_CMD = OMC_CMD_MEM;
        DBG_CMD_WDATA = 1'b0;
        WAKE_IRQ = '0;
        RESET_PIN_N = 1'b1;
        EXT_WAKE_N = 1'b1;
    end
    // one-cycle pulse: 0 wait, 1 stop, 2 halt instruction, 3 serial bkpt, 4 trace bkpt
    task automatic ev(input int k);
        @(posedge MCLK);
        ev_r <= 5'h01 << k;
        @(posedge MCLK);
        ev_r <= 5'h00;
    endtask
    // idle command lines change so a stale value is never mistaken for a live one
    task automatic cmd(input omc_cmd_e c, input logic w);
        @(posedge MCLK);
        DBG_CMD_VALID <= 1'b1;
        DBG_CMD <= c;
        DBG_CMD_WDATA <= w;
        @(posedge MCLK);
        DBG_CMD_VALID <= 1'b0;
        DBG_CMD <= omc_cmd_e'(~c);
        DBG_CMD_WDATA <= ~w;
    endtask
    // level held three cycles: 0 irq, 1 wake irq i, 2 reset pin, 3 external wake
    task automatic lvl(input int k, input int i);
        @(posedge MCLK);
        IRQ_REQ <= (k == 0);
        WAKE_IRQ[i] <= (k == 1);
        RESET_PIN_N <= (k != 2);
        EXT_WAKE_N <= (k != 3);
        repeat (3) @(posedge MCLK);
        IRQ_REQ <= 1'b0;
        WAKE_IRQ <= '0;
        RESET_PIN_N <= 1'b1;
        EXT_WAKE_N <= 1'b1;
    endtask
endmodule // omc_partner

// *** verif/test_operating_mode_controller.sv ***
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
// ========
// bench
module test_operating_mode_controller;
    import omc_pkg::*;
    localparam int NW = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic msel = 1'b1;
    logic clr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [10:0] seen;
    wire logic [10:0] pl;
    wire logic [31:0] rdat;
    wire logic [15:0] vaddr;
    wire logic [3:0] wsrc;
    wire logic ack, wx, sx, hx, sb, tb, irq, cv, cw, rpn, ewn;
    wire omc_cmd_e cmd;
    wire logic [NW-1:0] wirq;
    int error_cnt = 0;
    int num_checks = 0;
    int md;
    logic dbg, pdw;
    logic [1:0] sf;
    logic [4:0] opt;
    logic [4:0] topt[5] = '{5'h0f, 5'h0f, 5'h0b, 5'h01, 5'h0d};
    int tk[5] = '{0, 1, 3, 2, 2};
    always #10 clk = ~clk;
    omc_partner #(.NUM_WAKE(NW)) p (.MCLK(clk), .WAIT_EXEC(wx), .STOP_EXEC(sx), .HALT_TO_DEBUG_EXEC(hx),
        .SERIAL_DEBUG_BKPT(sb), .TRACE_DEBUG_BKPT(tb), .IRQ_REQ(irq), .DBG_CMD_VALID(cv), .DBG_CMD(cmd),
        .DBG_CMD_WDATA(cw), .WAKE_IRQ(wirq), .RESET_PIN_N(rpn), .EXT_WAKE_N(ewn));
    omc_top #(.NUM_WAKE(NW)) dut (.MCLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .MODE_SELECT_PIN(msel), .RESET_PIN_N(rpn), .EXT_WAKE_N(ewn), .WAIT_EXEC(wx), .STOP_EXEC(sx),
        .HALT_TO_DEBUG_EXEC(hx), .IRQ_REQ(irq), .DBG_CMD_VALID(cv), .DBG_CMD(cmd), .DBG_CMD_WDATA(cw),
        .SERIAL_DEBUG_BKPT(sb), .TRACE_DEBUG_BKPT(tb), .WAKE_IRQ(wirq), .CMD_ACCEPT(pl[8]),
        .CMD_REFUSE(pl[9]), .CMD_STATUS_ERR(pl[10]), .CPU_CLK_EN(), .CPU_SUSPEND(), .CLEAR_IRQ_MASK(pl[0]),
        .IRQ_STACK(pl[1]), .TRACE_STEP(pl[2]), .FETCH_VECTOR(pl[3]), .VECTOR_ADDR(vaddr),
        .TAKE_WAKE_VECTOR(pl[4]), .WAKE_SRC(wsrc), .ILLEGAL_OP_RESET(pl[5]), .SYS_RESET(pl[6]),
        .POR_RESTART(pl[7]), .BUS_CLK_EN(), .DEBUG_CLK_EN(), .REF_CLK_EN(), .REG_FULL(), .RETAIN_STATE(),
        .PIN_HOLD(), .POWER_OFF());
    // pulses are collected, since their exact cycle is left open
    always @(posedge clk)
    begin
        if (clr || rst)
            seen <= '0;
        else
            seen <= seen | pl;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && t < 20)
        begin
            @(posedge clk);
            t++;
        end
        q = rdat;
        cyc <= 1'b0;
        if (t >= 20)
            error_cnt++;
    endtask
    task automatic st;
        logic [31:0] q;
        wb(1'b0, 4'h4, 32'h0, q);
        chk("status", {24'h0, sf, pdw, dbg, 1'b0, 3'(md)}, q);
    endtask
    task automatic arm;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic pv(input string n, input logic [10:0] e, input logic [10:0] m);
        repeat (5) @(posedge clk);
        chk(n, {21'h0, e & m}, {21'h0, seen & m});
        st();
    endtask
    task automatic rs(input logic pin);
        @(posedge clk);
        rst <= 1'b1;
        msel <= pin;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        md = pin ? 0 : 1;
        {dbg, pdw, sf, opt} = '0;
        pv("boot", {7'h0, pin, 3'h0}, 11'h0ff);
        chk("vector", 32'h0000fffe, {16'h0, vaddr});
    endtask
    task automatic dc(input omc_cmd_e c, input logic w);
        logic acc;
        logic [10:0] e;
        acc = md == 1 || (md == 0 && c <= OMC_CMD_ENTER_DBG)
            || ((md == 2 || (md == 3 && sf[0])) && (c == OMC_CMD_ENTER_DBG || c == OMC_CMD_MEM_STAT));
        e = {acc && c == OMC_CMD_MEM_STAT && md > 1, !acc, acc, 5'h0, acc && c == OMC_CMD_TRACE, 2'h0};
        arm();
        p.cmd(c, w);
        if (acc && c == OMC_CMD_DREG)
            dbg = w;
        if (acc && c == OMC_CMD_ENTER_DBG)
            md = 1;
        if (acc && c == OMC_CMD_RESUME)
            md = 0;
        pv("command", e, 11'h704);
    endtask
    task automatic ev(input int k, input logic [7:0] e, input int m);
        arm();
        p.ev(k);
        md = m;
        pv("event", {3'h0, e}, 11'h0ff);
    endtask
    task automatic wk(input int k, input int i, input logic [7:0] e, input int m);
        arm();
        p.lvl(k, i);
        md = m;
        pv("wake", {3'h0, e}, {3'h0, e | 8'hf8});
    endtask
    task automatic stop;
        int m;
        m = !opt[0] ? 0 : (!dbg && !(opt[1] && opt[2]) && opt[3]) ? 4 : 3;
        if (opt[0])
            sf = {!dbg && opt[1] && opt[2], dbg};
        ev(1, {2'h0, !opt[0], 5'h0}, m);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    // ========
    // scenarios
    initial
    begin
        logic [31:0] q;
        int i;
        void'($urandom(32'hb7ab01aa));
        rs(1'b0);
        for (int c = 0; c < 7; c++)
            dc(omc_cmd_e'(c), 1'b0);
        for (int c = 4; c < 7; c++)
            dc(omc_cmd_e'(c), 1'($urandom));
        rs(1'b1);
        for (int k = 2; k < 5; k++)
        begin
            ev(k, 8'h00, 1);
            dc(OMC_CMD_RESUME, 1'b0);
        end
        ev(0, 8'h01, 2);
        for (int c = 0; c < 7; c++)
            dc(omc_cmd_e'(c), 1'b0);
        ev(0, 8'h01, 2);
        wk(0, 0, 8'h02, 0);
        stop();
        wb(1'b1, 4'hc, $urandom, q);
        wb(1'b1, 4'h4, 32'hffffffff, q);
        wb(1'b0, 4'h8, 32'h0, q);
        chk("unmapped", 32'h0, q);
        st();
        for (int t = 0; t < 5; t++)
        begin
            dc(OMC_CMD_DREG, t == 0);
            opt = topt[t];
            wb(1'b1, 4'h0, {27'h0, opt}, q);
            stop();
            i = $urandom % NW;
            if (t == 0)
            begin
                dc(OMC_CMD_MEM_STAT, 1'b0);
                dc(OMC_CMD_ENTER_DBG, 1'b0);
                dc(OMC_CMD_RESUME, 1'b0);
            end
            else if (md == 4)
            begin
                wk(1, i, 8'h00, 4);
                {pdw, opt, dbg} = 7'h40;
                wk(tk[t], 0, 8'h88, 0);
                wb(1'b0, 4'h0, 32'h0, q);
                chk("options", 32'h0, q);
            end
            else
            begin
                wk(tk[t], i, (tk[t] == 1) ? 8'h10 : 8'h48, 0);
                if (tk[t] == 1)
                    chk("wake source", i, {28'h0, wsrc});
            end
        end
        results();
    end
endmodule // test_operating_mode_controller
